//--- verilog/trap_pkg.sv
/*
  Package for the conditional trap and system-call unit: operation codes,
  widths, the issue and result carriers.
  Assumes a 32-bit core with one clock and an active-low async reset.
*/
package trap_pkg;

  localparam int DATA_W = 32;
  localparam int IMM_W = 16;
  // Largest positive immediate; the unsigned immediate form reaches
  // [0, IMM_POS_MAX] and [max - IMM_POS_MAX, max] only
  localparam logic [DATA_W-1:0] IMM_POS_MAX = 32'h0000_7fff;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;

  // Operation codes from the decode stage
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SYSTEM_CALL_INSTR,
    OP_TRAP_EQ_REG,
    OP_TRAP_EQ_IMM,
    OP_TRAP_GE_S_REG,
    OP_TRAP_GE_U_REG,
    OP_TRAP_GE_S_IMM,
    OP_TRAP_GE_U_IMM
  } trap_op_t;

  // Exception kinds toward exception entry
  typedef enum logic [1:0] {
    EXC_NONE,
    EXC_SYSTEM_CALL_INSTR,
    EXC_TRAP,
    EXC_RESERVED
  } exc_kind_t;

  typedef struct packed {
    logic valid;
    trap_op_t op;
    logic [DATA_W-1:0] first_source_reg;
    logic [DATA_W-1:0] second_source_reg;
    logic [IMM_W-1:0] imm;
    logic [31:0] pc;
  } trap_issue_t;

  typedef struct packed {
    logic raise;
    exc_kind_t kind;
    logic [31:0] epc;
  } trap_result_t;

endpackage

//--- verilog/trap_compare.sv
/*
  Combinational comparator for the trap family: equality, signed and
  unsigned greater-or-equal, against a register or the widened immediate.
  Assumes operands are stable during the cycle they are presented.
*/
`timescale 1ns/10ps
module trap_compare (
  // Operands
  input wire logic [trap_pkg::DATA_W-1:0] opa,
  input wire logic [trap_pkg::DATA_W-1:0] opb,
  // Results
  output logic is_eq,
  output logic ge_signed,
  output logic ge_unsigned
);

  always_comb begin
    is_eq = (opa == opb);
    ge_signed = ($signed(opa) >= $signed(opb));
    ge_unsigned = (opa >= opb);
  end

endmodule

//--- verilog/trap_unit.sv
/*
  Execution-stage trap and system-call unit: takes one decoded operation
  a cycle, evaluates the trap condition, and registers an exception
  request toward exception entry.
  Assumes decode presents source register values and the immediate, and
  that the instruction word's code field never reaches this block.
*/
`timescale 1ns/10ps

// Notes on behaviour
// - A system call raises a System Call exception whenever issue.valid is high.
// - The system-call code field is never looked at by the hardware.
// - Register equality trap raises Trap when both sources are equal.
// - Immediate equality trap widens the 16-bit immediate by sign first.
// - Signed register trap raises Trap when first >= second as signed.
// - Unsigned register trap raises Trap when first >= second unsigned.
// - Signed immediate trap compares against the sign-widened immediate.
// - Unsigned immediate trap sign-widens, then compares as unsigned.
// - Hence the unsigned immediate only reaches both ends of the range.
// - The code field of register trap forms is ignored by hardware.
// - In release 6 mode the three immediate traps are not provided.
// - These operations run in any state and raise only their own kind.
module trap_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Mode strap: release 6 behaviour
  input wire logic release6_mode,
  // Issue from decode
  input wire trap_pkg::trap_issue_t issue,
  // Exception request
  output trap_pkg::trap_result_t result
);

  ////////////////////////////////////////////////////////////////////////
  // Operand selection

  function automatic logic [trap_pkg::DATA_W-1:0] widen_imm(
    input logic [trap_pkg::IMM_W-1:0] imm
  );
    widen_imm = {{(trap_pkg::DATA_W-trap_pkg::IMM_W){imm[trap_pkg::IMM_W-1]}},
      imm};
  endfunction

  function automatic logic is_imm_op(input trap_pkg::trap_op_t op);
    is_imm_op = (op == trap_pkg::OP_TRAP_EQ_IMM) ||
      (op == trap_pkg::OP_TRAP_GE_S_IMM) ||
      (op == trap_pkg::OP_TRAP_GE_U_IMM);
  endfunction

  logic [trap_pkg::DATA_W-1:0] opb;
  logic is_eq;
  logic ge_s;
  logic ge_u;
  logic cond;
  trap_pkg::exc_kind_t kind_nxt;
  logic raise_nxt;
  logic r6_r;

  // Immediate forms compare against the widened immediate
  assign opb = is_imm_op(issue.op) ? widen_imm(issue.imm) :
    issue.second_source_reg;

  trap_compare u_cmp (
    .opa(issue.first_source_reg),
    .opb(opb),
    .is_eq(is_eq),
    .ge_signed(ge_s),
    .ge_unsigned(ge_u)
  );

  ////////////////////////////////////////////////////////////////////////
  // Condition and exception kind

  // Strap caught by a clock edge, not by the reset itself
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r6_r <= 1'b0;
    end else begin
      r6_r <= release6_mode;
    end
  end

  // No privilege or state gating on any of these operations
  always_comb begin
    cond = 1'b0;
    kind_nxt = trap_pkg::EXC_NONE;
    case (issue.op)
      trap_pkg::OP_SYSTEM_CALL_INSTR: begin
        cond = 1'b1;
        kind_nxt = trap_pkg::EXC_SYSTEM_CALL_INSTR;
      end
      trap_pkg::OP_TRAP_EQ_REG: begin
        cond = is_eq;
        kind_nxt = trap_pkg::EXC_TRAP;
      end
      trap_pkg::OP_TRAP_EQ_IMM: begin
        cond = is_eq && !r6_r;
        kind_nxt = trap_pkg::EXC_TRAP;
      end
      trap_pkg::OP_TRAP_GE_S_REG: begin
        cond = ge_s;
        kind_nxt = trap_pkg::EXC_TRAP;
      end
      trap_pkg::OP_TRAP_GE_U_REG: begin
        cond = ge_u;
        kind_nxt = trap_pkg::EXC_TRAP;
      end
      trap_pkg::OP_TRAP_GE_S_IMM: begin
        cond = ge_s && !r6_r;
        kind_nxt = trap_pkg::EXC_TRAP;
      end
      trap_pkg::OP_TRAP_GE_U_IMM: begin
        cond = ge_u && !r6_r;
        kind_nxt = trap_pkg::EXC_TRAP;
      end
      default: begin
        cond = 1'b0;
        kind_nxt = trap_pkg::EXC_NONE;
      end
    endcase
    raise_nxt = issue.valid && cond;
    if (!raise_nxt) begin
      kind_nxt = trap_pkg::EXC_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered exception request

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result.raise <= 1'b0;
      result.kind <= trap_pkg::EXC_NONE;
      result.epc <= trap_pkg::PC_RESET;
    end else begin
      result.raise <= raise_nxt;
      result.kind <= kind_nxt;
      // Epc only moves with a request, so a false trap leaves no trace
      if (raise_nxt) begin
        result.epc <= issue.pc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_system_call_instr_raises: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    issue.valid && issue.op == trap_pkg::OP_SYSTEM_CALL_INSTR |=> result.raise &&
    result.kind == trap_pkg::EXC_SYSTEM_CALL_INSTR)
    else $error("system call did not raise");

  a_epc_capture: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    issue.valid && issue.op == trap_pkg::OP_SYSTEM_CALL_INSTR |=>
    result.epc == $past(issue.pc))
    else $error("system call return address wrong");

  a_eq_reg_trap: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    issue.valid && issue.op == trap_pkg::OP_TRAP_EQ_REG |=>
    result.raise == $past(issue.first_source_reg ==
    issue.second_source_reg))
    else $error("register equality trap wrong");

  a_ge_signed_reg: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    issue.valid && issue.op == trap_pkg::OP_TRAP_GE_S_REG |=>
    result.raise == $past($signed(issue.first_source_reg) >=
    $signed(issue.second_source_reg)))
    else $error("signed register trap wrong");

  a_ge_unsigned_reg: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    issue.valid && issue.op == trap_pkg::OP_TRAP_GE_U_REG |=>
    result.raise == $past(issue.first_source_reg >=
    issue.second_source_reg))
    else $error("unsigned register trap wrong");

  a_eq_imm_trap: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    issue.valid && issue.op == trap_pkg::OP_TRAP_EQ_IMM && !r6_r |=>
    result.raise == $past(issue.first_source_reg ==
    {{16{issue.imm[15]}}, issue.imm}))
    else $error("immediate equality trap wrong");

  a_ge_s_imm: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    issue.valid && issue.op == trap_pkg::OP_TRAP_GE_S_IMM && !r6_r |=>
    result.raise == $past($signed(issue.first_source_reg) >=
    $signed({{16{issue.imm[15]}}, issue.imm})))
    else $error("signed immediate trap wrong");

  a_ge_u_imm: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    issue.valid && issue.op == trap_pkg::OP_TRAP_GE_U_IMM && !r6_r |=>
    result.raise == $past(issue.first_source_reg >=
    {{16{issue.imm[15]}}, issue.imm}))
    else $error("unsigned immediate trap wrong");

  a_r6_no_imm: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    r6_r && issue.valid && is_imm_op(issue.op) |=> !result.raise)
    else $error("immediate trap raised in release 6 mode");

  a_false_quiet: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    !result.raise |-> result.kind == trap_pkg::EXC_NONE &&
    result.epc == $past(result.epc))
    else $error("side effect without exception");

  // Valid low must gate even an unconditional system call
  a_invalid_quiet: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    !issue.valid |=> !result.raise)
    else $error("raise without a valid operation");

  a_none_quiet: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    issue.valid && issue.op == trap_pkg::OP_NONE |=> !result.raise)
    else $error("empty operation raised");

  a_trap_kind: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    issue.valid && issue.op != trap_pkg::OP_SYSTEM_CALL_INSTR ##1 result.raise |->
    result.kind == trap_pkg::EXC_TRAP)
    else $error("trap raised wrong kind");

endmodule

//--- verification/decode_feeder.sv
/*
  Decode-stage model: presents one operation a cycle on the issue carrier.
  Assumes the caller steps it just after a falling clock edge.
*/
`timescale 1ns/10ps
module decode_feeder (
  // Issue toward the unit
  output trap_pkg::trap_issue_t issue
);
  logic [31:0] last_r;
  initial begin
    issue = '0;
    last_r = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////
  // Idle cycles scramble operands, so stale values never look valid
  task automatic put(input logic v, input trap_pkg::trap_op_t op,
      input logic [31:0] a, input logic [31:0] b, input logic [15:0] imm,
      input logic [31:0] pc);
    if (v) begin
      issue = '{1'b1, op, a, b, imm, pc};
    end else begin
      last_r = ~last_r;
      issue = '{1'b0, op, last_r, ~last_r, last_r[15:0], last_r};
    end
  endtask
endmodule

//--- verification/conditional_trap_and_system_call_instr_tb.sv
/*
  Self-checking bench for the trap and system-call unit.
  Assumes the decode model in decode_feeder and the design package.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module conditional_trap_and_system_call_instr_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic release6_mode = 1'b0;
  trap_pkg::trap_issue_t issue;
  trap_pkg::trap_result_t result;
  int fail_count = 0;
  int checks_done = 0;
  logic [31:0] epc_x = trap_pkg::PC_RESET;
  logic [31:0] pc_n = 32'h0000_1000;
  always #2 ref_clk = ~ref_clk;
  decode_feeder i_feed (.issue(issue));
  trap_unit i_dut (.ref_clk(ref_clk), .rstn(rstn),
    .release6_mode(release6_mode), .issue(issue), .result(result));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic hit(trap_pkg::trap_op_t op, logic [31:0] a,
      logic [31:0] b, logic [15:0] imm);
    logic [31:0] w;
    logic r6;
    w = {{16{imm[15]}}, imm};
    r6 = release6_mode;
    case (op)
      trap_pkg::OP_SYSTEM_CALL_INSTR: return 1'b1;
      trap_pkg::OP_TRAP_EQ_REG: return a == b;
      trap_pkg::OP_TRAP_GE_S_REG: return $signed(a) >= $signed(b);
      trap_pkg::OP_TRAP_GE_U_REG: return a >= b;
      trap_pkg::OP_TRAP_EQ_IMM: return !r6 && a == w;
      trap_pkg::OP_TRAP_GE_S_IMM: return !r6 && $signed(a) >= $signed(w);
      trap_pkg::OP_TRAP_GE_U_IMM: return !r6 && a >= w;
      default: return 1'b0;
    endcase
  endfunction
  // Idle cycle: a system call with valid low must be ignored
  task automatic idle();
    i_feed.put(1'b0, trap_pkg::OP_SYSTEM_CALL_INSTR, '0, '0, '0, '0);
    @(negedge ref_clk);
    `CHK("idle raise", 1'b0, result.raise)
    `CHK("idle kind", trap_pkg::EXC_NONE, result.kind)
    `CHK("idle epc", epc_x, result.epc)
  endtask
  task automatic op(trap_pkg::trap_op_t o, logic [31:0] a, logic [31:0] b,
      logic [15:0] imm);
    logic h;
    trap_pkg::exc_kind_t k;
    h = hit(o, a, b, imm);
    k = trap_pkg::EXC_TRAP;
    if (o == trap_pkg::OP_SYSTEM_CALL_INSTR) k = trap_pkg::EXC_SYSTEM_CALL_INSTR;
    if (!h) k = trap_pkg::EXC_NONE;
    pc_n = pc_n + 32'h0000_0004;
    if (h) epc_x = pc_n;
    i_feed.put(1'b1, o, a, b, imm, pc_n);
    @(negedge ref_clk);
    `CHK("raise", h, result.raise)
    `CHK("kind", k, result.kind)
    `CHK("epc", epc_x, result.epc)
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_system_call_instr();
    op(trap_pkg::OP_SYSTEM_CALL_INSTR, 32'h0000_0001, 32'h0000_0002, 16'hffff);
    op(trap_pkg::OP_SYSTEM_CALL_INSTR, 32'hffff_ffff, 32'h1234_5678, 16'h0000);
    op(trap_pkg::OP_NONE, 32'h0000_0005, 32'h0000_0005, 16'h0005);
    idle();
    $display("test system_call_instr done");
  endtask
  task automatic t_equal();
    op(trap_pkg::OP_TRAP_EQ_REG,
      32'h0000_0005, 32'h0000_0005, 16'h1234);
    op(trap_pkg::OP_TRAP_EQ_REG, 32'h0000_0005, 32'h8000_0005, 16'h0000);
    op(trap_pkg::OP_TRAP_EQ_IMM, 32'hffff_ffff, 32'h0000_0000, 16'hffff);
    op(trap_pkg::OP_TRAP_EQ_IMM, 32'h0000_ffff, 32'hffff_ffff, 16'hffff);
    idle();
    $display("test equal done");
  endtask
  task automatic t_ge();
    op(trap_pkg::OP_TRAP_GE_S_REG,
      32'hffff_ffff, 32'h0000_0000, 16'h0000);
    op(trap_pkg::OP_TRAP_GE_S_REG,
      32'h0000_0000, 32'h8000_0000, 16'h0000);
    op(trap_pkg::OP_TRAP_GE_U_REG,
      32'hffff_ffff, 32'h0000_0000, 16'h0000);
    op(trap_pkg::OP_TRAP_GE_U_REG,
      32'h0000_0000, 32'h0000_0001, 16'h0000);
    op(trap_pkg::OP_TRAP_GE_S_IMM,
      32'hffff_fffe, 32'h0000_0000, 16'hffff);
    op(trap_pkg::OP_TRAP_GE_S_IMM,
      32'h0000_0000, 32'h0000_0000, 16'h8000);
    op(trap_pkg::OP_TRAP_GE_U_IMM,
      32'h7fff_ffff, 32'h0000_0000, 16'h8000);
    op(trap_pkg::OP_TRAP_GE_U_IMM,
      32'hffff_8000, 32'h0000_0000, 16'h8000);
    op(trap_pkg::OP_TRAP_GE_U_IMM,
      32'h0000_7ffe, 32'h0000_0000, 16'h7fff);
    op(trap_pkg::OP_TRAP_GE_U_IMM,
      32'h0000_7fff, 32'h0000_0000, 16'h7fff);
    idle();
    $display("test compare done");
  endtask
  // Reset in mid-run clears request and return address; the first issue
  // at the first edge after release must be taken
  task automatic t_reset();
    op(trap_pkg::OP_SYSTEM_CALL_INSTR, 32'h0000_0000, 32'h0000_0000, 16'h0000);
    rstn = 1'b0;
    @(negedge ref_clk);
    `CHK("mid reset raise", 1'b0, result.raise)
    `CHK("mid reset kind", trap_pkg::EXC_NONE, result.kind)
    `CHK("mid reset epc", trap_pkg::PC_RESET, result.epc)
    rstn = 1'b1;
    epc_x = trap_pkg::PC_RESET;
    op(trap_pkg::OP_TRAP_EQ_REG, 32'h0000_0005, 32'h0000_0005, 16'h0000);
    idle();
    $display("test reset done");
  endtask
  // Strap is registered once, so one idle cycle is enough; two are run before use
  task automatic t_rel6();
    release6_mode = 1'b1;
    idle();
    idle();
    op(trap_pkg::OP_TRAP_EQ_IMM, 32'h0000_0003, 32'h0000_0000, 16'h0003);
    op(trap_pkg::OP_TRAP_GE_S_IMM,
      32'h0000_0003, 32'h0000_0000, 16'h0000);
    op(trap_pkg::OP_TRAP_GE_U_IMM,
      32'hffff_ffff, 32'h0000_0000, 16'h0000);
    op(trap_pkg::OP_TRAP_GE_U_REG,
      32'h0000_0003, 32'h0000_0003, 16'h0000);
    op(trap_pkg::OP_TRAP_EQ_REG, 32'h0000_0007, 32'h0000_0007, 16'h0000);
    op(trap_pkg::OP_SYSTEM_CALL_INSTR, 32'h0000_0000, 32'h0000_0000, 16'h0000);
    idle();
    $display("test release6 done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    $display("ERROR watchdog expected 1 seen 0");
    complete_run();
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    `CHK("reset raise", 1'b0, result.raise)
    `CHK("reset kind", trap_pkg::EXC_NONE, result.kind)
    `CHK("reset epc", trap_pkg::PC_RESET, result.epc)
    t_system_call_instr();
    t_equal();
    t_ge();
    t_reset();
    t_rel6();
    complete_run();
  end
endmodule
